// ===== rtl/rrc_freq_calc.sv
`timescale 1ns/100ps
`default_nettype none
module rrc_freq_calc
  import rrc_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire rrc_cfg_t cfg_in,
  output logic [PROD_W-1:0] freq_hz_out,
  output logic valid_out,
  output logic div_zero_out
);

  rrc_state_t state;
  logic [PROD_W-1:0] quot;
  logic [RATE_W-1:0] rem;
  logic [COUNT_W-1:0] step;

  // Every operand is widened first so no partial product is cut to 16 bits
  wire [PROD_W-1:0] product = PROD_W'(cfg_in.unit_rate_hz) *
                              PROD_W'(cfg_in.unit_rate_multiplier) *
                              PROD_W'(cfg_in.fec_numerator);
  wire [RATE_W:0] trial = {rem, quot[PROD_W-1]};
  wire [RATE_W:0] denom_ext = {1'b0, cfg_in.fec_denominator};
  wire fits = trial >= denom_ext;
  wire [RATE_W:0] trial_left = trial - denom_ext;
  wire [RATE_W-1:0] next_rem = fits ? trial_left[RATE_W-1:0] : trial[RATE_W-1:0];
  wire denom_zero = cfg_in.fec_denominator == '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Multiply, then restoring divide one quotient bit per cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= RRC_IDLE;
      quot <= '0;
      rem <= '0;
      step <= '0;
      freq_hz_out <= '0;
      div_zero_out <= 1'b0;
    end else if (start_in) begin
      state <= RRC_MULT;
    end else begin
      case (state)
        RRC_MULT: begin
          quot <= product;
          rem <= '0;
          step <= '0;
          div_zero_out <= denom_zero;
          state <= denom_zero ? RRC_DONE : RRC_DIVIDE;
          if (denom_zero) begin
            freq_hz_out <= '0;
          end
        end
        RRC_DIVIDE: begin
          rem <= next_rem;
          quot <= {quot[PROD_W-2:0], fits};
          step <= step + 1'b1;
          if (step == DIV_STEPS) begin
            freq_hz_out <= {quot[PROD_W-2:0], fits};
            state <= RRC_DONE;
          end
        end
        default: state <= state;
      endcase
    end
  end

  // A pending restart hides a result that no longer matches the registers
  assign valid_out = (state == RRC_DONE) && !start_in;

endmodule
`default_nettype wire

// ===== rtl/rrc_pkg.sv
package rrc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RATE_W = 16;
  localparam int RATIO_W = 32;
  localparam int PROD_W = 48;
  localparam int COUNT_W = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [7:0] ADDR_FREEZE = 8'h0d;
  localparam logic [7:0] ADDR_UNIT_RATE = 8'h10;
  localparam logic [7:0] ADDR_MULTIPLIER = 8'h12;
  localparam logic [7:0] ADDR_FEC_RATIO = 8'h14;

  localparam logic [7:0] RST_FREEZE = 8'h00;
  localparam logic [15:0] RST_UNIT_RATE = 16'h9c40;
  localparam logic [15:0] RST_MULTIPLIER = 16'h0f30;
  localparam logic [31:0] RST_FEC_RATIO = 32'h0001_0001;

  localparam logic [7:0] FREEZE_ON = 8'h01;
  localparam logic [7:0] FREEZE_OFF = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Ratio register fields
  localparam int NUMER_MSB = 31;
  localparam int NUMER_LSB = 16;
  localparam int DENOM_MSB = 15;
  localparam int DENOM_LSB = 0;

  // Lane of a 16-bit register inside the 32-bit byte helpers
  localparam logic LANE16_HI = 1'b1;
  localparam logic [5:0] DIV_STEPS = 6'h2f;

  ////////////////////////////////////////////////////////////////////////////////
  // Supported unit rates in hertz
  localparam logic [15:0] RATE_1K = 16'h03e8;
  localparam logic [15:0] RATE_2K = 16'h07d0;
  localparam logic [15:0] RATE_5K = 16'h1388;
  localparam logic [15:0] RATE_6K25 = 16'h186a;
  localparam logic [15:0] RATE_8K = 16'h1f40;
  localparam logic [15:0] RATE_10K = 16'h2710;
  localparam logic [15:0] RATE_12K5 = 16'h30d4;
  localparam logic [15:0] RATE_25K = 16'h61a8;
  localparam logic [15:0] RATE_40K = 16'h9c40;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rrc_bus_t;

  typedef struct packed {
    logic [RATE_W-1:0] unit_rate_hz;
    logic [RATE_W-1:0] unit_rate_multiplier;
    logic [RATE_W-1:0] fec_numerator;
    logic [RATE_W-1:0] fec_denominator;
  } rrc_cfg_t;

  typedef enum logic [1:0] {
    RRC_IDLE = 2'b00,
    RRC_MULT = 2'b01,
    RRC_DIVIDE = 2'b11,
    RRC_DONE = 2'b10
  } rrc_state_t;

  function automatic logic rrc_rate_supported(input logic [15:0] rate);
    rrc_rate_supported = (rate == RATE_1K) || (rate == RATE_2K) || (rate == RATE_5K) ||
                         (rate == RATE_6K25) || (rate == RATE_8K) || (rate == RATE_10K) ||
                         (rate == RATE_12K5) || (rate == RATE_25K) || (rate == RATE_40K);
  endfunction

  // Lane 0 is the lowest byte address and holds the most significant byte
  function automatic logic [7:0] rrc_get_byte(input logic [31:0] value, input logic [1:0] lane);
    case (lane)
      2'h0: rrc_get_byte = value[31:24];
      2'h1: rrc_get_byte = value[23:16];
      2'h2: rrc_get_byte = value[15:8];
      default: rrc_get_byte = value[7:0];
    endcase
  endfunction

  function automatic logic [31:0] rrc_put_byte(input logic [31:0] value, input logic [1:0] lane,
                                               input logic [7:0] data);
    rrc_put_byte = value;
    case (lane)
      2'h0: rrc_put_byte[31:24] = data;
      2'h1: rrc_put_byte[23:16] = data;
      2'h2: rrc_put_byte[15:8] = data;
      default: rrc_put_byte[7:0] = data;
    endcase
  endfunction

endpackage

// ===== rtl/rrc_regs.sv
`timescale 1ns/100ps
`default_nettype none
module rrc_regs
  import rrc_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire rrc_bus_t bus_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic rvalid_out,
  output logic latched_status_freeze_out,
  output var rrc_cfg_t cfg_out,
  output logic unit_rate_supported_out,
  output logic fec_active_out,
  output logic [PROD_W-1:0] expected_freq_hz_out,
  output logic expected_freq_valid_out,
  output logic fec_ratio_error_out
);

  logic [7:0] status_freeze_control;
  logic [15:0] input0_unit_rate;
  logic [15:0] input0_rate_multiplier;
  logic [31:0] input0_fec_ratio;
  logic freeze_active;
  logic recalc;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire hit_freeze = bus_in.addr == ADDR_FREEZE;
  wire hit_rate = bus_in.addr[7:1] == ADDR_UNIT_RATE[7:1];
  wire hit_mult = bus_in.addr[7:1] == ADDR_MULTIPLIER[7:1];
  wire hit_ratio = bus_in.addr[7:2] == ADDR_FEC_RATIO[7:2];
  wire [1:0] lane16 = {LANE16_HI, bus_in.addr[0]};
  wire [1:0] lane32 = bus_in.addr[1:0];

  wire wr_freeze = bus_in.wr && hit_freeze;
  wire wr_rate = bus_in.wr && hit_rate;
  wire wr_mult = bus_in.wr && hit_mult;
  wire wr_ratio = bus_in.wr && hit_ratio;
  wire wr_cfg = wr_rate || wr_mult || wr_ratio;

  wire [31:0] put_rate = rrc_put_byte({16'h0000, input0_unit_rate}, lane16, bus_in.wdata);
  wire [31:0] put_mult = rrc_put_byte({16'h0000, input0_rate_multiplier}, lane16, bus_in.wdata);
  wire [31:0] next_ratio = rrc_put_byte(input0_fec_ratio, lane32, bus_in.wdata);
  wire [15:0] next_rate = put_rate[15:0];
  wire [15:0] next_mult = put_mult[15:0];

  wire [7:0] next_rdata =
    hit_freeze ? status_freeze_control :
    hit_rate ? rrc_get_byte({16'h0000, input0_unit_rate}, lane16) :
    hit_mult ? rrc_get_byte({16'h0000, input0_rate_multiplier}, lane16) :
    hit_ratio ? rrc_get_byte(input0_fec_ratio, lane32) : READ_UNMAPPED;

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      status_freeze_control <= RST_FREEZE;
    end else if (wr_freeze) begin
      status_freeze_control <= bus_in.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      input0_unit_rate <= RST_UNIT_RATE;
      input0_rate_multiplier <= RST_MULTIPLIER;
      input0_fec_ratio <= RST_FEC_RATIO;
    end else begin
      if (wr_rate) begin
        input0_unit_rate <= next_rate;
      end
      if (wr_mult) begin
        input0_rate_multiplier <= next_mult;
      end
      if (wr_ratio) begin
        input0_fec_ratio <= next_ratio;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Freeze of latched status updates; other codes leave it unchanged
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      freeze_active <= 1'b0;
    end else if (wr_freeze && bus_in.wdata == FREEZE_ON) begin
      freeze_active <= 1'b1;
    end else if (wr_freeze && bus_in.wdata == FREEZE_OFF) begin
      freeze_active <= 1'b0;
    end
  end

  assign latched_status_freeze_out = freeze_active;

  ////////////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= READ_UNMAPPED;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= bus_in.rd;
      if (bus_in.rd) begin
        rdata_out <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded configuration
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      recalc <= 1'b1;
    end else begin
      recalc <= wr_cfg;
    end
  end

  assign cfg_out.unit_rate_hz = input0_unit_rate;
  assign cfg_out.unit_rate_multiplier = input0_rate_multiplier;
  assign cfg_out.fec_numerator = input0_fec_ratio[NUMER_MSB:NUMER_LSB];
  assign cfg_out.fec_denominator = input0_fec_ratio[DENOM_MSB:DENOM_LSB];

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      unit_rate_supported_out <= 1'b1;
      fec_active_out <= 1'b0;
    end else begin
      unit_rate_supported_out <= rrc_rate_supported(input0_unit_rate);
      fec_active_out <= cfg_out.fec_numerator != cfg_out.fec_denominator;
    end
  end

  rrc_freq_calc u_calc (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .start_in(recalc),
    .cfg_in(cfg_out),
    .freq_hz_out(expected_freq_hz_out),
    .valid_out(expected_freq_valid_out),
    .div_zero_out(fec_ratio_error_out)
  );

endmodule
`default_nettype wire

// ===== sim/rrc_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rrc_regs_bench
  import rrc_pkg::*;
;
  logic clk_in;
  logic srst_in = 1'b1;
  rrc_bus_t bus_in = '0;
  logic [7:0] rdata, r;
  logic rvalid, frz, sup, fa, fv, fe;
  rrc_cfg_t cfg;
  logic [47:0] fq;
  int errors = 0;
  int n_compared = 0;
  logic [15:0] rst_rows [9] = '{16'h0d00, 16'h109c, 16'h1140, 16'h120f, 16'h1330, 16'h1400,
    16'h1501, 16'h1600, 16'h1701};
  logic [23:0] rows [11] = '{24'h106161, 24'h11a8a8, 24'h121818, 24'h136a6a, 24'h144141,
    24'h15bebe, 24'h163b3b, 24'h178080, 24'h0d0101, 24'h0d0000, 24'h205500};
  logic [15:0] rates [10] = '{16'h03e8, 16'h07d0, 16'h1388, 16'h186a, 16'h1f40, 16'h2710,
    16'h30d4, 16'h61a8, 16'h9c40, 16'h1234};
  rrc_regs uut (.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus_in), .rdata_out(rdata),
    .rvalid_out(rvalid), .latched_status_freeze_out(frz), .cfg_out(cfg),
    .unit_rate_supported_out(sup), .fec_active_out(fa), .expected_freq_hz_out(fq),
    .expected_freq_valid_out(fv), .fec_ratio_error_out(fe));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    bus_in = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk_in);
    bus_in.wr = 1'b0;
  endtask
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    bus_in = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk_in);
    bus_in.rd = 1'b0;
    check("rvalid", rvalid, 1'b1);
    d = rdata;
  endtask
  // Result drops at the edge that takes a config write; two cycles are skipped, then it is awaited
  task automatic wait_done();
    repeat (2) @(negedge clk_in);
    for (int i = 0; i < 100 && fv !== 1'b1; i++) @(negedge clk_in);
    check("freq valid", fv, 1'b1);
  endtask
  task automatic final_report();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    errors++;
    final_report();
  end
  initial begin
    repeat (6) @(negedge clk_in);
    srst_in = 1'b0;
    foreach (rows[i]) begin
      wr_byte(rows[i][23:16], rows[i][15:8]);
      rd_byte(rows[i][23:16], r);
      check("read back", r, rows[i][7:0]);
    end
    wait_done();
    check("fec freq", fq, 48'h61a8 * 48'h186a * 48'h41be / 48'h3b80);
    check("fec active", fa, 1'b1);
    wr_byte(8'h0d, 8'h01);
    wr_byte(8'h0d, 8'h02);
    check("freeze hold", frz, 1'b1);
    wr_byte(8'h0d, 8'h00);
    check("freeze off", frz, 1'b0);
    wr_byte(8'h16, 8'h00);
    wr_byte(8'h17, 8'h00);
    wait_done();
    check("zero denom flag", fe, 1'b1);
    check("zero denom freq", fq, 48'h0);
    foreach (rates[i]) begin
      wr_byte(8'h10, rates[i][15:8]);
      wr_byte(8'h11, rates[i][7:0]);
      @(negedge clk_in);
      check("unit rate", cfg.unit_rate_hz, rates[i]);
      check("rate supported", sup, i < 9);
    end
    // Mid-run reset must restore every register and restart the calculation
    wr_byte(8'h0d, 8'h01);
    srst_in = 1'b1;
    repeat (6) @(negedge clk_in);
    srst_in = 1'b0;
    foreach (rst_rows[i]) begin
      rd_byte(rst_rows[i][15:8], r);
      check("reset byte", r, rst_rows[i][7:0]);
    end
    wait_done();
    check("reset freq", fq, 48'h9c40 * 48'h0f30);
    check("reset fec", fa, 1'b0);
    check("reset denom error", fe, 1'b0);
    check("reset freeze", frz, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire

// ===== sim/rrc_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module rrc_regs_checker
  import rrc_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire rrc_bus_t bus_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic latched_status_freeze_out,
  input wire rrc_cfg_t cfg_out,
  input wire logic unit_rate_supported_out,
  input wire logic fec_active_out,
  input wire logic [PROD_W-1:0] expected_freq_hz_out,
  input wire logic expected_freq_valid_out,
  input wire logic fec_ratio_error_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire logic w = bus_in.wr;
  wire logic [7:0] a = bus_in.addr;
  wire logic [7:0] d = bus_in.wdata;
  wire logic ok = cfg_out.unit_rate_hz inside {RATE_1K, RATE_2K, RATE_5K, RATE_6K25, RATE_8K,
    RATE_10K, RATE_12K5, RATE_25K, RATE_40K};
  wire logic ne = cfg_out.fec_numerator != cfg_out.fec_denominator;
  wire logic [47:0] prod = PROD_W'(cfg_out.unit_rate_hz) * PROD_W'(cfg_out.unit_rate_multiplier)
    * PROD_W'(cfg_out.fec_numerator);
  freeze_on_a: assert property (w && a == 8'h0d && d == 8'h01 |=> latched_status_freeze_out)
    else $error("freeze not set");
  freeze_off_a: assert property (w && a == 8'h0d && d == 8'h00 |=> !latched_status_freeze_out)
    else $error("freeze not cleared");
  rate_msb_a: assert property (w && a == 8'h10 |=> cfg_out.unit_rate_hz[15:8] == $past(d))
    else $error("rate high byte wrong");
  numer_msb_a: assert property (w && a == 8'h14 |=> cfg_out.fec_numerator[15:8] == $past(d))
    else $error("numerator high byte wrong");
  denom_lsb_a: assert property (w && a == 8'h17 |=> cfg_out.fec_denominator[7:0] == $past(d))
    else $error("denominator low byte wrong");
  rate_ok_a: assert property (unit_rate_supported_out == $past(ok))
    else $error("rate support flag wrong");
  fec_flag_a: assert property (fec_active_out == $past(ne))
    else $error("fec flag wrong");
  freq_value_a: assert property ($rose(expected_freq_valid_out) && cfg_out.fec_denominator != 0
    |-> expected_freq_hz_out == prod / PROD_W'(cfg_out.fec_denominator))
    else $error("frequency wrong");
  cover property ($rose(latched_status_freeze_out));
  cover property ($rose(expected_freq_valid_out) && fec_active_out);
  cover property ($rose(fec_ratio_error_out));
endmodule
bind rrc_regs rrc_regs_checker chk (.clk_in, .srst_in, .bus_in, .rdata_out, .rvalid_out,
  .latched_status_freeze_out, .cfg_out, .unit_rate_supported_out, .fec_active_out,
  .expected_freq_hz_out, .expected_freq_valid_out, .fec_ratio_error_out);
`default_nettype wire
